// File: hw/spi_nv_pkg.sv
package spi_nv_pkg;

  // ------------------------------------------------------------------
  // array geometry and clocking
  // ------------------------------------------------------------------
  localparam int MEM_ADDR_W = 11;
  localparam int BYTE_W = 8;
  localparam int ADDR_HI_W = MEM_ADDR_W - BYTE_W;
  localparam int MCLK_HZ = 50_000_000;
  localparam int SCK_MAX_HZ = 15_000_000;
  // shortest serial clock half period in mclk cycles, rounded down
  localparam int SCK_HALF_CYC = (MCLK_HZ / (2 * SCK_MAX_HZ) < 1) ? 1 :
                                MCLK_HZ / (2 * SCK_MAX_HZ);
  localparam int WBUF_DEPTH = 2;

  // ------------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_SR_RD = 8'h05;
  localparam logic [7:0] OP_SR_WR = 8'h01;
  localparam logic [7:0] OP_MEM_RD = 8'h03;
  localparam logic [7:0] OP_MEM_WR = 8'h02;

  // ------------------------------------------------------------------
  // status byte layout and reset values
  // ------------------------------------------------------------------
  localparam int STAT_WPEN_BIT = 7;
  localparam int STAT_BP1_BIT = 3;
  localparam int STAT_BP0_BIT = 2;
  localparam int STAT_WEL_BIT = 1;
  localparam logic [2:0] STAT_NV_RST = 3'h0;
  localparam logic WEL_RST = 1'b0;

  // ------------------------------------------------------------------
  // synchroniser lane positions
  // ------------------------------------------------------------------
  localparam int SYN_CS = 0;
  localparam int SYN_SCK = 1;
  localparam int SYN_SI = 2;
  localparam int SYN_HOLD = 3;
  localparam int SYN_WP = 4;
  localparam int SYN_N = 5;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_OPCODE = 4'b0001,
    ST_ADDR_HI = 4'b0010,
    ST_ADDR_LO = 4'b0011,
    ST_WDATA = 4'b0100,
    ST_RDATA = 4'b0101,
    ST_SR_OUT = 4'b0110,
    ST_SR_IN = 4'b0111,
    ST_IGNORE = 4'b1000
  } phase_type;

  typedef struct packed {
    logic [MEM_ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } wr_entry_type;

endpackage

// File: hw/mem_port_if.sv
`timescale 1ns/1ps
interface mem_port_if #(parameter int AW = 11) ();
  logic wr_valid;
  logic wr_ready;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_req;
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_valid;

  modport ctl (
    output wr_valid, wr_addr, wr_data, rd_req, rd_addr,
    input wr_ready, rd_data, rd_valid
  );
  modport mem (
    input wr_valid, wr_addr, wr_data, rd_req, rd_addr,
    output wr_ready, rd_data, rd_valid
  );
endinterface

// File: hw/nv_byte_mem.sv
`timescale 1ns/1ps
module nv_byte_mem #(
  parameter int AW = 11
) (
  input wire logic mclk,
  input wire logic sys_rst,
  mem_port_if.mem port
);
  logic [7:0] cell_q [2**AW];
  logic [7:0] rd_data_d;
  logic [7:0] rd_data_q;
  logic rd_valid_q;

  // ------------------------------------------------------------------
  // read port wins; a pending write simply waits one cycle
  // ------------------------------------------------------------------
  assign port.wr_ready = ~port.rd_req;
  assign port.rd_data = rd_data_q;
  assign port.rd_valid = rd_valid_q;

  always_comb begin
    rd_data_d = rd_data_q;
    if (port.rd_req) begin
      rd_data_d = cell_q[port.rd_addr];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= port.rd_req;
    end
  end

  // array has no reset: its content outlives power-up
  always_ff @(posedge mclk) begin
    if (port.wr_valid && port.wr_ready) begin
      cell_q[port.wr_addr] <= port.wr_data;
    end
  end
endmodule

// File: hw/spi_nv_memory_slave.sv
`timescale 1ns/1ps
// Overview of operation
// - With chip select high the block idles, ignores all inputs and leaves its output undriven.
// - Serial input is taken on rising clock edges only, serial output changes on falling ones.
// - Logic is static, so the serial clock may run at any rate up to 15 MHz or stop anywhere.
// - While hold is low the operation is frozen and clock and chip select changes are ignored.
// - With write protect low every status write is rejected.
// - Serial output is driven only while read data goes out, never during hold.
// - A two-byte address follows the command; its top 5 bits are ignored, 11 bits pick a byte.
// - Each written byte is committed on its eighth bit and the block is never busy.
// - Idle-low and idle-high clocks both work, with sampling on rising edges.
// - The first byte after chip select falls is decoded as one of six commands.
// - All transfers are 8-bit units, most significant bit first.
// - The write enable latch is clear at power-up, set by its command, cleared by writes or clear.
module spi_nv_memory_slave
  import spi_nv_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe
);

  mem_port_if #(.AW(MEM_ADDR_W)) mif ();

  nv_byte_mem #(.AW(MEM_ADDR_W)) u_mem (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .port(mif.mem)
  );

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [SYN_N-1:0] pin_raw;
  logic [SYN_N-1:0] sync1_q;
  logic [SYN_N-1:0] sync2_q;
  logic sck_prev_q;

  assign pin_raw = {wp_n, hold_n, si, sck, cs_n};

  for (genvar i = 0; i < SYN_N; i++) begin : g_sync
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        sync1_q[i] <= 1'b1;
        sync2_q[i] <= 1'b1;
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sync2_q[SYN_SCK];
    end
  end

  logic cs_s;
  logic hold_s;
  logic wp_s;
  logic si_s;
  logic act;
  logic rise;
  logic fall;

  assign cs_s = sync2_q[SYN_CS];
  assign hold_s = sync2_q[SYN_HOLD];
  assign wp_s = sync2_q[SYN_WP];
  assign si_s = sync2_q[SYN_SI];
  assign act = hold_s & ~cs_s;
  // pure edge detection, no timeouts: any clock idle level and any stop is fine
  assign rise = act & sync2_q[SYN_SCK] & ~sck_prev_q;
  assign fall = act & ~sync2_q[SYN_SCK] & sck_prev_q;

  // ------------------------------------------------------------------
  // serial engine state
  // ------------------------------------------------------------------
  phase_type st_q, st_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [MEM_ADDR_W-1:0] addr_q, addr_d;
  logic [2:0] stat_q, stat_d;
  logic wel_q, wel_d;
  logic wok_q, wok_d;
  logic isrd_q, isrd_d;
  logic wrote_q, wrote_d;
  logic drv_q, drv_d;
  logic so_q, so_d;
  logic so_oe_q, so_oe_d;
  logic [7:0] rx;
  logic byte_done;
  logic [7:0] status_byte;
  logic push;
  logic rd_req;
  logic [MEM_ADDR_W-1:0] rd_addr;

  assign rx = {sh_q[6:0], si_s};
  assign byte_done = rise && (bit_q == 3'h7);

  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_WPEN_BIT] = stat_q[2];
    status_byte[STAT_BP1_BIT] = stat_q[1];
    status_byte[STAT_BP0_BIT] = stat_q[0];
    status_byte[STAT_WEL_BIT] = wel_q;
  end

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    tx_d = tx_q;
    addr_d = addr_q;
    stat_d = stat_q;
    wel_d = wel_q;
    wok_d = wok_q;
    isrd_d = isrd_q;
    wrote_d = wrote_q;
    drv_d = drv_q;
    so_d = so_q;
    push = 1'b0;
    rd_req = 1'b0;
    rd_addr = addr_q;
    if (!hold_s) begin
      // everything but tx_q and so_oe holds its value, so release resumes mid-byte
      st_d = st_q;
    end else if (cs_s) begin
      // frame end: back to standby, a finished write drops the latch
      st_d = ST_IDLE;
      bit_d = 3'h0;
      drv_d = 1'b0;
      if (wrote_q) begin
        wel_d = 1'b0;
      end
      wrote_d = 1'b0;
    end else if (st_q == ST_IDLE) begin
      st_d = ST_OPCODE; // new frame after a chip select fall
      bit_d = 3'h0;
    end else begin
      if (rise) begin
        sh_d = rx; // input taken on the rising edge only
        bit_d = bit_q + 3'h1;
      end
      if (fall && drv_q) begin
        so_d = tx_q[7]; // output moves on the falling edge, msb first
        tx_d = {tx_q[6:0], 1'b0};
      end
      if (fall && (st_q == ST_RDATA || st_q == ST_SR_OUT)) begin
        if (!drv_q) begin
          so_d = tx_q[7];
          tx_d = {tx_q[6:0], 1'b0};
        end
        drv_d = 1'b1; // drive only while read data goes out
      end
      if (byte_done) begin
        case (st_q)
          ST_OPCODE: begin
            st_d = ST_IGNORE;
            case (rx)
              OP_SET_WEL: wel_d = 1'b1;
              OP_CLR_WEL: wel_d = 1'b0;
              OP_SR_RD: begin
                tx_d = status_byte;
                st_d = ST_SR_OUT;
              end
              OP_SR_WR: begin
                wok_d = wel_q & wp_s; // protect pin low refuses it
                st_d = ST_SR_IN;
              end
              OP_MEM_RD: begin
                isrd_d = 1'b1;
                st_d = ST_ADDR_HI;
              end
              OP_MEM_WR: begin
                isrd_d = 1'b0;
                wok_d = wel_q;
                st_d = ST_ADDR_HI;
              end
              default: st_d = ST_IGNORE;
            endcase
          end
          ST_ADDR_HI: begin
            addr_d[MEM_ADDR_W-1:BYTE_W] = rx[ADDR_HI_W-1:0]; // upper 5 bits dropped
            st_d = ST_ADDR_LO;
          end
          ST_ADDR_LO: begin
            addr_d[BYTE_W-1:0] = rx;
            if (isrd_q) begin
              rd_req = 1'b1;
              rd_addr = {addr_q[MEM_ADDR_W-1:BYTE_W], rx};
              st_d = ST_RDATA;
            end else begin
              st_d = ST_WDATA;
            end
          end
          ST_WDATA: begin
            push = wok_q; // byte committed at its eighth bit
            wrote_d = wrote_q | wok_q;
            addr_d = addr_q + 1'b1;
          end
          ST_RDATA: begin
            rd_req = 1'b1;
            rd_addr = addr_q + 1'b1;
            addr_d = addr_q + 1'b1;
          end
          ST_SR_OUT: tx_d = status_byte;
          ST_SR_IN: begin
            if (wok_q) begin
              stat_d = {rx[STAT_WPEN_BIT], rx[STAT_BP1_BIT], rx[STAT_BP0_BIT]};
              wrote_d = 1'b1;
            end
            st_d = ST_IGNORE;
          end
          default: st_d = st_q; // later bytes of a frame are dropped
        endcase
      end
    end
    // a fetch still in flight when hold drops must land, or resume finds a stale byte
    if (mif.rd_valid) begin
      tx_d = mif.rd_data;
    end
    so_oe_d = drv_d & hold_s & ~cs_s; // undriven in standby and hold
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= '0;
      stat_q <= STAT_NV_RST;
      wel_q <= WEL_RST;
      wok_q <= 1'b0;
      isrd_q <= 1'b0;
      wrote_q <= 1'b0;
      drv_q <= 1'b0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      addr_q <= addr_d;
      stat_q <= stat_d;
      wel_q <= wel_d;
      wok_q <= wok_d;
      isrd_q <= isrd_d;
      wrote_q <= wrote_d;
      drv_q <= drv_d;
      so_q <= so_d;
      so_oe_q <= so_oe_d;
    end
  end

  assign so = so_q;
  assign so_oe = so_oe_q;
  assign mif.rd_req = rd_req;
  assign mif.rd_addr = rd_addr;

  // ------------------------------------------------------------------
  // two-entry write buffer: a read in the same cycle stalls the drain
  // ------------------------------------------------------------------
  wr_entry_type wbuf_q [WBUF_DEPTH];
  wr_entry_type wbuf_d [WBUF_DEPTH];
  logic wptr_q, wptr_d;
  logic rptr_q, rptr_d;
  logic [1:0] cnt_q, cnt_d;
  logic pop;

  assign pop = (cnt_q != 2'h0) && mif.wr_ready;
  assign mif.wr_valid = (cnt_q != 2'h0);
  assign mif.wr_addr = wbuf_q[rptr_q].addr;
  assign mif.wr_data = wbuf_q[rptr_q].data;

  always_comb begin
    wbuf_d = wbuf_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    cnt_d = cnt_q;
    if (push && cnt_q != 2'h2) begin
      wbuf_d[wptr_q] = '{addr: addr_q, data: rx};
      wptr_d = ~wptr_q;
    end
    if (pop) begin
      rptr_d = ~rptr_q;
    end
    cnt_d = cnt_q + {1'b0, push && cnt_q != 2'h2} - {1'b0, pop};
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wbuf_q <= '{default: '0};
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wbuf_q <= wbuf_d;
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_addr_done_rd;
    byte_done && st_q == ST_ADDR_LO && isrd_q && hold_s && !cs_s;
  endsequence
  sequence s_data_ready;
    ##1 mif.rd_valid ##1 (tx_q == $past(mif.rd_data));
  endsequence

  property p_standby;
    (cs_s && hold_s) |=> (st_q == ST_IDLE && !so_oe_q && bit_q == 3'h0);
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");

  property p_hold_freeze;
    !hold_s |=> ($stable(st_q) && $stable(bit_q) && $stable(sh_q) && !so_oe_q);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("hold did not freeze");

  property p_so_on_fall;
    $changed(so_q) |-> $past(fall);
  endproperty
  a_so_on_fall: assert property (p_so_on_fall) else $error("output moved off a fall");

  property p_msb_first;
    (fall && drv_q && hold_s && !cs_s) |=> (so_q == $past(tx_q[7]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bit order wrong");

  property p_wp_block;
    (byte_done && st_q == ST_OPCODE && rx == OP_SR_WR && !wp_s && hold_s && !cs_s)
      |=> !wok_q;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("protected status write");

  property p_stat_change;
    $changed(stat_q) |-> $past(st_q == ST_SR_IN && wok_q && byte_done);
  endproperty
  a_stat_change: assert property (p_stat_change) else $error("status changed");

  property p_wel_set;
    (byte_done && st_q == ST_OPCODE && rx == OP_SET_WEL && hold_s && !cs_s) |=> wel_q;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set");

  property p_commit;
    (push && hold_s && !cs_s) |=> ##[0:3] (mif.wr_valid && mif.wr_ready);
  endproperty
  a_commit: assert property (p_commit) else $error("byte not committed");

  property p_addr_hi;
    (byte_done && st_q == ST_ADDR_HI && hold_s && !cs_s)
      |=> (addr_q[MEM_ADDR_W-1:BYTE_W] == $past(rx[ADDR_HI_W-1:0]));
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("address high wrong");

  property p_read_load;
    s_addr_done_rd |-> s_data_ready;
  endproperty
  a_read_load: assert property (p_read_load) else $error("read data not loaded");

  property p_one_cmd;
    (st_q == ST_IGNORE && !cs_s) |=> (st_q == ST_IGNORE);
  endproperty
  a_one_cmd: assert property (p_one_cmd) else $error("second command taken");

  property p_oe_only_read;
    so_oe_q |-> (st_q == ST_RDATA || st_q == ST_SR_OUT);
  endproperty
  a_oe_only_read: assert property (p_oe_only_read) else $error("output driven");

endmodule

// File: testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic mclk,
  input wire logic so_pin,
  input wire logic so_oe,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  output logic wp_n
);
  // ------------------------------------------------------------
  // serial master, edges launched on mclk
  // ------------------------------------------------------------
  localparam int HALF = 4; // 160 ns clock, well under the ceiling
  logic cpol;
  logic oe_in_hold;

  initial begin
    cpol = 1'b0;
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
    oe_in_hold = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic set_mode(input logic m);
    cpol <= m; // idle level picks mode 0 or 3
    sck <= m;
    wait_n(HALF);
  endtask

  task automatic set_wp(input logic v);
    wp_n <= v;
    wait_n(HALF);
  endtask

  task automatic open_frame();
    cs_n <= 1'b0; // fresh falling edge before every opcode
    wait_n(HALF);
  endtask

  task automatic xfer(input logic [7:0] tx, input int hb, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si <= tx[i]; // msb first, eight bits a unit
      wait_n(HALF);
      if (i == hb) begin
        hold_n <= 1'b0; // hold moves only with the clock low
        wait_n(6);
        sck <= 1'b1;
        wait_n(HALF);
        sck <= 1'b0;
        wait_n(HALF);
        oe_in_hold = so_oe;
        hold_n <= 1'b1;
        wait_n(6);
      end
      sck <= 1'b1;
      wait_n(HALF);
      // so only moves after falls, so late in the high phase it is settled
      rx[i] = so_pin;
    end
  endtask

  task automatic close_frame();
    sck <= cpol;
    wait_n(HALF);
    cs_n <= 1'b1; // deselect after every operation
    // shared bus: other slaves get clocked while this one is deselected
    for (int k = 0; k < 8; k++) begin
      sck <= ~sck;
      si <= ~si;
      wait_n(HALF);
    end
  endtask
endmodule

// File: testbench/tb_spi_nv_memory_slave.sv
`timescale 1ns/1ps
module tb_spi_nv_memory_slave
  import spi_nv_pkg::*;
  ;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cs_n, sck, si, hold_n, wp_n, so, so_oe;
  wire so_pin = so_oe ? so : 1'bz;
  logic [47:0] rxw = 48'h0;
  logic [7:0] v;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;

  always #10 mclk = ~mclk;

  spi_nv_memory_slave i_spi_nv_memory_slave (
    .mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe)
  );

  host_model i_host_model (
    .mclk(mclk), .so_pin(so_pin), .so_oe(so_oe), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .wp_n(wp_n)
  );

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // generous: the whole run needs well under a third of this
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // frame helpers
  // ------------------------------------------------------------
  task automatic frame(input int n, input logic [47:0] tx, input int hb);
    logic [7:0] rx;
    i_host_model.open_frame();
    for (int i = n - 1; i >= 0; i--) begin
      i_host_model.xfer(tx[8*i +: 8], (hb / 8 == n - 1 - i) ? hb % 8 : -1, rx);
      rxw = {rxw[39:0], rx};
    end
    i_host_model.close_frame();
  endtask

  task automatic read_sr(output logic [7:0] r);
    frame(2, {OP_SR_RD, 8'h00}, -1);
    r = rxw[7:0];
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check({7'h0, so_oe}, 8'h00);
    read_sr(v);
    check(v, 8'h00);
    check({7'h0, so_oe}, 8'h00);
  endtask

  task automatic t_latch();
    frame(1, OP_SET_WEL, -1);
    read_sr(v);
    check(v, 8'h02);
    frame(2, {OP_CLR_WEL, OP_SET_WEL}, -1);
    read_sr(v);
    check(v, 8'h00);
    // unknown command: the rest of the frame must be dropped
    frame(2, {8'h0b, OP_SET_WEL}, -1);
    read_sr(v);
    check(v, 8'h00);
  endtask

  task automatic t_write_read();
    frame(1, OP_SET_WEL, -1);
    // a third byte keeps the prefetch after later reads of 0x000 defined
    frame(6, {OP_MEM_WR, 16'hffff, 8'ha5, 8'h3c, 8'h5a}, -1);
    read_sr(v);
    check(v, 8'h00);
    i_host_model.set_mode(1'b1);
    frame(6, {OP_MEM_RD, 16'hf7ff, 24'h000000}, -1);
    check(rxw[23:16], 8'ha5);
    check(rxw[15:8], 8'h3c);
    check(rxw[7:0], 8'h5a);
    frame(4, {OP_MEM_RD, 16'h0800, 8'h00}, -1);
    check(rxw[7:0], 8'h3c);
    i_host_model.set_mode(1'b0);
  endtask

  task automatic t_no_latch();
    frame(4, {OP_MEM_WR, 16'h0000, 8'h99}, -1);
    frame(4, {OP_MEM_RD, 16'h0000, 8'h00}, -1);
    check(rxw[7:0], 8'h3c);
  endtask

  task automatic t_hold();
    frame(4, {OP_MEM_RD, 16'h07ff, 8'h00}, 28);
    check(rxw[7:0], 8'ha5);
    check({7'h0, i_host_model.oe_in_hold}, 8'h00);
  endtask

  task automatic t_protect();
    frame(1, OP_SET_WEL, -1);
    i_host_model.set_wp(1'b0);
    frame(2, {OP_SR_WR, 8'hff}, -1);
    read_sr(v);
    check(v, 8'h02);
    i_host_model.set_wp(1'b1);
    frame(2, {OP_SR_WR, 8'hff}, -1);
    read_sr(v);
    check(v, 8'h8c);
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_reset();
    t_latch();
    t_write_read();
    t_no_latch();
    t_hold();
    t_protect();
    give_verdict();
  end
endmodule
